// ==== hdl/pcm_mode_ctrl.sv ====
// per-channel operating mode control with its command registers
`default_nettype none
`include "pcm_defines.svh"

module pcm_mode_ctrl
  import pcm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire pcm_req_t i_req,
  input wire pcm_meas_t [3:0] i_meas,
  input wire logic [3:0] i_alloc_ok,
  input wire logic [3:0][7:0] i_class_police,
  input wire logic [3:0] i_class_double_fb,
  output logic [7:0] o_rdata,
  output logic [3:0] o_power_enable,
  output logic [3:0] o_detect_active,
  output logic [3:0] o_class_active,
  output logic [3:0] o_dc_disconnect_en,
  output logic [3:0][7:0] o_police,
  output logic [3:0] o_double_fb,
  output logic [3:0] o_clear_busy
);

  localparam int NCH = `PCM_NUM_CH;
  localparam logic [22:0] CLEAR_CYC = 23'(`PCM_CLEAR_CYCLES);

  // registered state
  logic [7:0] opmode;
  logic [7:0] disc;
  logic [3:0] detect_enable_bit;
  logic [3:0] class_enable_bit;
  logic [3:0] power_enabled_bit;
  logic [3:0] power_good_bit;
  logic [3:0] power_good_change_flag;
  logic [3:0] power_enable_change_flag;
  pcm_state_t [3:0] st;
  logic [3:0][15:0] tmr;
  logic [3:0][22:0] clr_cnt;
  logic [3:0][7:0] police;
  logic [3:0] double_fb;
  logic [7:0] rdata;

  logic [7:0] next_opmode;
  logic [7:0] next_disc;
  logic [3:0] next_detect_enable_bit;
  logic [3:0] next_class_enable_bit;
  logic [3:0] next_power_enabled_bit;
  logic [3:0] next_power_good_bit;
  logic [3:0] next_power_good_change_flag;
  logic [3:0] next_power_enable_change_flag;
  pcm_state_t [3:0] next_st;
  logic [3:0][15:0] next_tmr;
  logic [3:0][22:0] next_clr_cnt;
  logic [3:0][7:0] next_police;
  logic [3:0] next_double_fb;
  logic [7:0] next_rdata;

  logic wr_mode;
  logic wr_disc;
  logic wr_en;
  logic wr_pwon;
  logic rd_event;

  assign wr_mode = i_req.wr && (i_req.addr == `PCM_ADDR_OPMODE);
  assign wr_disc = i_req.wr && (i_req.addr == `PCM_ADDR_DISC);
  assign wr_en = i_req.wr && (i_req.addr == `PCM_ADDR_ENABLE);
  assign wr_pwon = i_req.wr && (i_req.addr == `PCM_ADDR_PWRON);
  assign rd_event = i_req.rd && (i_req.addr == `PCM_ADDR_EVENT);

  always_comb begin
    pcm_mode_t old_m;
    pcm_mode_t new_m;
    logic enter_off;
    logic pwon;
    old_m = PCM_MODE_OFF;
    new_m = PCM_MODE_OFF;
    enter_off = 1'b0;
    pwon = 1'b0;
    next_opmode = wr_mode ? i_req.wdata : opmode;
    next_disc = wr_disc ? i_req.wdata : disc;
    next_detect_enable_bit = detect_enable_bit;
    next_class_enable_bit = class_enable_bit;
    next_power_enabled_bit = power_enabled_bit;
    next_power_good_bit = power_good_bit;
    // reading the event register clears it; a new event in the same cycle wins
    next_power_good_change_flag = rd_event ? 4'h0 : power_good_change_flag;
    next_power_enable_change_flag = rd_event ? 4'h0 : power_enable_change_flag;
    next_st = st;
    next_tmr = tmr;
    next_clr_cnt = clr_cnt;
    next_police = police;
    next_double_fb = double_fb;
    if (wr_en) begin
      next_detect_enable_bit = i_req.wdata[3:0];
      next_class_enable_bit = i_req.wdata[7:4];
    end
    for (int n = 0; n < NCH; n++) begin
      old_m = pcm_mode_t'(opmode[2*n +: 2]);
      new_m = pcm_mode_t'(next_opmode[2*n +: 2]);
      enter_off = (new_m == PCM_MODE_OFF) && (old_m != PCM_MODE_OFF);
      pwon = wr_pwon && i_req.wdata[n] && (new_m != PCM_MODE_OFF);
      if (tmr[n] != 16'h0000) begin
        next_tmr[n] = tmr[n] - 16'h0001;
      end
      if (clr_cnt[n] != 23'h00_0000) begin
        next_clr_cnt[n] = clr_cnt[n] - 23'h00_0001;
      end
      if (enter_off) begin
        // channel-local clear only; other channels keep their bits
        next_detect_enable_bit[n] = 1'b0;
        next_class_enable_bit[n] = 1'b0;
        next_power_enabled_bit[n] = 1'b0;
        next_power_good_bit[n] = 1'b0;
        next_police[n] = `PCM_POLICE_OFF;
        next_double_fb[n] = 1'b0;
        next_st[n] = PCM_ST_IDLE;
        next_tmr[n] = 16'h0000;
        next_clr_cnt[n] = CLEAR_CYC;
      end else if (new_m == PCM_MODE_OFF) begin
        next_st[n] = PCM_ST_IDLE;
        next_power_enabled_bit[n] = 1'b0;
        next_power_good_bit[n] = 1'b0;
      end else if (old_m == PCM_MODE_SEMI && new_m == PCM_MODE_MANUAL &&
                   st[n] == PCM_ST_COOL) begin
        next_st[n] = PCM_ST_IDLE;
        next_tmr[n] = 16'h0000;
      end else if (pwon) begin
        next_st[n] = PCM_ST_POWERED;
        next_power_enabled_bit[n] = 1'b1;
        next_police[n] = i_class_police[n];
        next_double_fb[n] = i_class_double_fb[n];
      end else begin
        unique case (st[n])
          PCM_ST_IDLE: begin
            if (new_m == PCM_MODE_MANUAL) begin
              // a single cycle per enable; bits self-clear when used
              if (detect_enable_bit[n]) begin
                next_st[n] = PCM_ST_DETECT;
                next_tmr[n] = `PCM_DET_CYCLES;
                next_detect_enable_bit[n] = 1'b0;
              end else if (class_enable_bit[n]) begin
                next_st[n] = PCM_ST_CLASS;
                next_tmr[n] = `PCM_CLS_CYCLES;
                next_class_enable_bit[n] = 1'b0;
              end
            end else if (new_m == PCM_MODE_SEMI && detect_enable_bit[n]) begin
              next_st[n] = PCM_ST_DETECT;
              next_tmr[n] = `PCM_DET_CYCLES;
            end else if (new_m == PCM_MODE_AUTO && detect_enable_bit[n] &&
                         class_enable_bit[n]) begin
              next_st[n] = PCM_ST_DETECT;
              next_tmr[n] = `PCM_DET_CYCLES;
            end
          end
          PCM_ST_DETECT: begin
            if (tmr[n] == 16'h0000) begin
              if (new_m == PCM_MODE_MANUAL) begin
                next_st[n] = class_enable_bit[n] ? PCM_ST_CLASS : PCM_ST_IDLE;
                next_tmr[n] = class_enable_bit[n] ? `PCM_CLS_CYCLES : 16'h0000;
                next_class_enable_bit[n] = 1'b0;
              end else if (class_enable_bit[n] && i_meas[n].det_valid) begin
                next_st[n] = PCM_ST_CLASS;
                next_tmr[n] = `PCM_CLS_CYCLES;
              end else begin
                next_st[n] = PCM_ST_IDLE;
              end
            end
          end
          PCM_ST_CLASS: begin
            if (tmr[n] == 16'h0000) begin
              if (new_m == PCM_MODE_AUTO && i_meas[n].cls_valid && i_alloc_ok[n]) begin
                next_st[n] = PCM_ST_POWERED;
                next_power_enabled_bit[n] = 1'b1;
                next_police[n] = i_class_police[n];
                next_double_fb[n] = i_class_double_fb[n];
              end else begin
                // semiauto keeps cycling unpowered; power waits for the host
                next_st[n] = PCM_ST_IDLE;
              end
            end
          end
          PCM_ST_POWERED: begin
            next_power_good_bit[n] = i_meas[n].power_good;
            if (i_meas[n].fault) begin
              next_power_enabled_bit[n] = 1'b0;
              next_power_good_bit[n] = 1'b0;
              next_st[n] = PCM_ST_COOL;
              next_tmr[n] = `PCM_COOL_CYCLES;
            end
          end
          PCM_ST_COOL: begin
            if (tmr[n] == 16'h0000) begin
              next_st[n] = PCM_ST_IDLE;
            end
          end
          default: begin
            next_st[n] = PCM_ST_IDLE;
          end
        endcase
      end
      if ((power_good_bit[n] && !next_power_good_bit[n]) ||
          (power_enabled_bit[n] && !next_power_enabled_bit[n])) begin
        next_power_good_change_flag[n] = 1'b1;
        next_power_enable_change_flag[n] = 1'b1;
      end
    end
  end

  // read data holds between reads, so the host may fetch it late
  always_comb begin
    next_rdata = rdata;
    if (i_req.rd) begin
      unique case (i_req.addr)
        `PCM_ADDR_OPMODE: next_rdata = opmode;
        `PCM_ADDR_DISC: next_rdata = disc;
        `PCM_ADDR_ENABLE: next_rdata = {class_enable_bit, detect_enable_bit};
        `PCM_ADDR_EVENT: next_rdata = {power_good_change_flag, power_enable_change_flag};
        `PCM_ADDR_POWER: next_rdata = {power_good_bit, power_enabled_bit};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      opmode <= `PCM_OPMODE_RST;
      disc <= `PCM_DISC_RST;
      detect_enable_bit <= 4'h0;
      class_enable_bit <= 4'h0;
      power_enabled_bit <= 4'h0;
      power_good_bit <= 4'h0;
      power_good_change_flag <= 4'h0;
      power_enable_change_flag <= 4'h0;
      st <= '{default: PCM_ST_IDLE};
      tmr <= '0;
      clr_cnt <= '0;
      police <= {NCH{`PCM_POLICE_OFF}};
      double_fb <= 4'h0;
    end else begin
      opmode <= next_opmode;
      disc <= next_disc;
      detect_enable_bit <= next_detect_enable_bit;
      class_enable_bit <= next_class_enable_bit;
      power_enabled_bit <= next_power_enabled_bit;
      power_good_bit <= next_power_good_bit;
      power_good_change_flag <= next_power_good_change_flag;
      power_enable_change_flag <= next_power_enable_change_flag;
      st <= next_st;
      tmr <= next_tmr;
      clr_cnt <= next_clr_cnt;
      police <= next_police;
      double_fb <= next_double_fb;
    end
  end

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      o_detect_active[n] = (st[n] == PCM_ST_DETECT);
      o_class_active[n] = (st[n] == PCM_ST_CLASS);
      o_clear_busy[n] = (clr_cnt[n] != 23'h00_0000);
    end
  end

  assign o_rdata = rdata;
  assign o_power_enable = power_enabled_bit;
  assign o_dc_disconnect_en = disc[3:0];
  assign o_police = police;
  assign o_double_fb = double_fb;

endmodule
`default_nettype wire

// ==== hdl/pcm_defines.svh ====
// constants for the per-channel power mode controller
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH

`define PCM_NUM_CH 4
`define PCM_ADDR_OPMODE 8'h12
`define PCM_ADDR_DISC 8'h13
`define PCM_ADDR_ENABLE 8'h14
`define PCM_ADDR_PWRON 8'h19
`define PCM_ADDR_EVENT 8'h02
`define PCM_ADDR_POWER 8'h10
`define PCM_OPMODE_RST 8'h00
`define PCM_DISC_RST 8'h0F
`define PCM_DISC_MASK 8'h0F
`define PCM_POLICE_OFF 8'hFF
`define PCM_CLEAR_TIME_US 5000
`define PCM_CLK_MHZ 25
`define PCM_CLEAR_CYCLES (`PCM_CLEAR_TIME_US * `PCM_CLK_MHZ)
`define PCM_DET_CYCLES 16'h0040
`define PCM_CLS_CYCLES 16'h0020
`define PCM_COOL_CYCLES 16'h0100

`endif

// ==== hdl/pcm_pkg.sv ====
// types shared by the power mode controller
`default_nettype none
package pcm_pkg;
  typedef enum logic [1:0] {
    PCM_MODE_OFF = 2'h0,
    PCM_MODE_MANUAL = 2'h1,
    PCM_MODE_SEMI = 2'h2,
    PCM_MODE_AUTO = 2'h3
  } pcm_mode_t;

  typedef enum logic [4:0] {
    PCM_ST_IDLE = 5'b0_0001,
    PCM_ST_DETECT = 5'b0_0010,
    PCM_ST_CLASS = 5'b0_0100,
    PCM_ST_POWERED = 5'b0_1000,
    PCM_ST_COOL = 5'b1_0000
  } pcm_state_t;

  // register access from the serial command decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcm_req_t;

  // measurement results from the analog front end, one set per channel
  typedef struct packed {
    logic det_valid;
    logic cls_valid;
    logic power_good;
    logic fault;
  } pcm_meas_t;
endpackage
`default_nettype wire

// ==== verification/pcm_mode_ctrl_assertions.sv ====
// port assertions for the mode controller
`default_nettype none
module pcm_mode_ctrl_assertions
  import pcm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire pcm_req_t i_req,
  input wire logic [3:0] o_power_enable,
  input wire logic [3:0] o_detect_active,
  input wire logic [3:0] o_class_active,
  input wire logic [3:0] o_dc_disconnect_en,
  input wire logic [3:0][7:0] o_police,
  input wire logic [3:0] o_clear_busy
);
  logic [7:0] mode, next_mode;
  logic [3:0] off_ch;
  logic pon0, wr_en;
  assign pon0 = i_req.wr && i_req.addr == 8'h19 && i_req.wdata[0];
  assign wr_en = i_req.wr && i_req.addr == 8'h14;
  // shadow of the mode byte, the design keeps it internal
  always_comb next_mode = (i_req.wr && i_req.addr == 8'h12) ? i_req.wdata : mode;
  always_ff @(posedge i_core_clk) mode <= i_rst ? 8'h00 : next_mode;
  for (genvar c = 0; c < 4; c++) begin : g_off
    assign off_ch[c] = mode[2*c+:2] == 2'h0;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_reset;
    $fell(i_rst) |-> o_dc_disconnect_en == 4'hF && o_police[0] == 8'hFF;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset values");
  property p_disc;
    i_req.wr && i_req.addr == 8'h13 |=> o_dc_disconnect_en == $past(i_req.wdata[3:0]);
  endproperty
  a_disc: assert property (p_disc) else $error("bad disconnect bits");
  property p_off_idle;
    ((o_power_enable | o_detect_active | o_class_active) & off_ch) == 4'h0;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("off channel active");
  property p_off_police;
    off_ch[0] |-> o_police[0] == 8'hFF;
  endproperty
  a_off_police: assert property (p_off_police) else $error("bad policing");
  property p_off_busy;
    !off_ch[0] && next_mode[1:0] == 2'h0 |=> o_clear_busy[0] [*8];
  endproperty
  a_off_busy: assert property (p_off_busy) else $error("no clear window");
  property p_pwon;
    pon0 && !off_ch[0] |=> o_power_enable[0];
  endproperty
  a_pwon: assert property (p_pwon) else $error("no power on");
  property p_semi;
    $rose(o_power_enable[0]) && mode[1:0] == 2'h2 |-> $past(pon0);
  endproperty
  a_semi: assert property (p_semi) else $error("semiauto powered alone");
  property p_manual;
    $rose(o_detect_active[0]) && mode[1:0] == 2'h1 |-> $past(wr_en, 2);
  endproperty
  a_manual: assert property (p_manual) else $error("manual detect alone");
  c_manual: cover property (mode[1:0] == 2'h1 && $fell(o_class_active[0]));
  c_auto: cover property (mode[1:0] == 2'h3 && $rose(o_power_enable[0]));
  c_off: cover property ($rose(o_clear_busy[0]));
endmodule
bind pcm_mode_ctrl pcm_mode_ctrl_assertions u_pcm_mode_ctrl_assertions (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(i_req), .o_power_enable(o_power_enable),
  .o_detect_active(o_detect_active), .o_class_active(o_class_active),
  .o_dc_disconnect_en(o_dc_disconnect_en), .o_police(o_police), .o_clear_busy(o_clear_busy));
`default_nettype wire

// ==== verification/pcm_host_model.sv ====
// host model issuing one register access at a time
`default_nettype none
module pcm_host_model
  import pcm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output var pcm_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // remap, allocation and foldback setup stay with the host, outside this block
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge i_core_clk);
    o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_core_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge i_core_clk);
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// bench for the mode controller: host accesses and front-end stimulus
`default_nettype none
module tb_top
  import pcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0, i_rst = 1'b1, clr = 1'b0;
  logic [3:0] alloc = 4'h0, pwr, det, cls, disc, busy, sd, sc, dfb;
  pcm_meas_t [3:0] meas = {4{4'hC}};
  logic [3:0][7:0] pol;
  logic [7:0] rdata, q;
  pcm_req_t req;
  int fails = 0, total_checks = 0;
  always #20 i_core_clk = ~i_core_clk;
  always_ff @(posedge i_core_clk) begin
    sd <= clr ? 4'h0 : sd | det;
    sc <= clr ? 4'h0 : sc | cls;
  end
  pcm_host_model u_pcm_host_model (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_req(req));
  pcm_mode_ctrl u_pcm_mode_ctrl (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req),
    .i_meas(meas), .i_alloc_ok(alloc), .i_class_police({4{8'h5A}}),
    .i_class_double_fb(4'hF), .o_rdata(rdata), .o_power_enable(pwr), .o_detect_active(det),
    .o_class_active(cls), .o_dc_disconnect_en(disc), .o_police(pol), .o_double_fb(dfb),
    .o_clear_busy(busy));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_pcm_host_model.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_pcm_host_model.access(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  // clears the seen-activity flags, then lets n cycles pass
  task automatic watch(input int n);
    clr <= 1;
    @(posedge i_core_clk);
    clr <= 0;
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst <= 0;
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h0F);
    wr(8'h13, 8'hA5);
    rd(8'h13, 8'hA5);
    check({4'h0, disc}, 8'h05);
    rd(8'h7E, 8'h00);
    $display("registers done");
    wr(8'h12, 8'h01);
    wr(8'h19, 8'h02);
    check({4'h0, pwr}, 8'h00);
    wr(8'h14, 8'h11);
    watch(300);
    check({sc, sd}, 8'h11);
    watch(200);
    check({sc, sd}, 8'h00);
    $display("manual done");
    wr(8'h12, 8'h05);
    wr(8'h19, 8'h03);
    check({4'h0, pwr}, 8'h03);
    check(pol[0], 8'h5A);
    check({4'h0, dfb}, 8'h03);
    wr(8'h12, 8'h04);
    check({pwr, busy}, 8'h21);
    check(pol[0], 8'hFF);
    check({4'h0, dfb}, 8'h02);
    rd(8'h02, 8'h11);
    rd(8'h02, 8'h00);
    $display("off entry done");
    wr(8'h12, 8'h02);
    wr(8'h14, 8'h01);
    watch(300);
    check({sc, sd}, 8'h01);
    watch(300);
    check({sc, sd}, 8'h01);
    wr(8'h14, 8'h10);
    watch(100);
    watch(200);
    check({sc, sd}, 8'h00);
    wr(8'h14, 8'h11);
    watch(400);
    check({sc, sd}, 8'h11);
    check({4'h0, pwr}, 8'h00);
    wr(8'h19, 8'h01);
    watch(200);
    check({sc, sd}, 8'h00);
    meas <= {4{4'hE}};
    rd(8'h10, 8'h11);
    rd(8'h02, 8'h22);
    wr(8'h14, 8'h00);
    meas <= {4{4'hD}};
    rd(8'h02, 8'h11);
    meas <= {4{4'hC}};
    check({4'h0, pwr}, 8'h00);
    wr(8'h12, 8'h01);
    wr(8'h14, 8'h01);
    watch(20);
    check({sc, sd}, 8'h01);
    $display("semiauto done");
    wr(8'h12, 8'h00);
    alloc <= 4'hF;
    wr(8'h12, 8'h03);
    watch(100);
    check({4'h0, pwr}, 8'h00);
    wr(8'h14, 8'h11);
    watch(400);
    check({4'h0, pwr}, 8'h01);
    $display("auto done");
    report_and_stop;
  end
endmodule
`default_nettype wire
